// File: srm_pkg.sv
// shared constants for the round-robin converter monitor: widths, timing counts,
// bias-level codes and mux selections.
// assumes one 200 MHz clock; every count below is in cycles or divider ticks.
`default_nettype none

package srm_pkg;
  // converter resolution and grouping
  localparam int RES_BITS = 10;          // bits per conversion result
  localparam int NUM_CONV = 3;           // low group, high group, temperature
  localparam int GROUP_CH = 8;           // analog inputs per voltage converter
  localparam int NUM_VIN = 16;           // analog inputs in total
  localparam int CH_W = 3;               // width of a group channel index

  // timing, in clock cycles and approximation ticks
  localparam int CLK_MHZ = 200;          // system clock rate
  localparam int TICK_DIV = 8;           // clocks per approximation tick
  localparam int ACQ_TICKS = 4;          // ticks the array samples the input
  localparam int SETTLE_TICKS = 16;      // ticks the chopped bias settles per step

  // remote diode bias levels: base current and its three multiples
  localparam logic [1:0] BIAS_BASE = 2'h0;
  localparam logic [1:0] BIAS_N1 = 2'h1;
  localparam logic [1:0] BIAS_N2 = 2'h2;
  localparam logic [1:0] BIAS_N3 = 2'h3;

  // temperature mux selections
  localparam logic TEMP_SEL_LOCAL = 1'b0;
  localparam logic TEMP_SEL_REMOTE = 1'b1;

  // default weights for the series-resistance cancelling combination
  localparam int RCOMB_W1 = 3;
  localparam int RCOMB_W2 = -3;
  localparam int RCOMB_W3 = 1;
  localparam int RCOMB_SHIFT = 0;
endpackage : srm_pkg

`default_nettype wire

// File: srm_sar_engine.sv
// one successive-approximation engine: acquisition, isolation, then one
// phi1/phi2 trial per result bit, msb first.
// assumes i_cmp is already synchronised and i_tick is a one-cycle divider pulse.
`timescale 1ns/10ps
`default_nettype none

module srm_sar_engine
  import srm_pkg::*;
#(
  parameter int N = RES_BITS,
  parameter int ACQ = ACQ_TICKS
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_cmp,
  output logic o_busy,
  output logic o_acq,
  output logic o_phi1,
  output logic o_phi2,
  output logic [N-1:0] o_code,
  output logic [N-1:0] o_result,
  output logic o_done
);
  typedef enum logic [2:0] {S_IDLE, S_ACQ, S_ISO, S_PHI1, S_GAP1, S_PHI2, S_GAP2} srm_sar_state_t;

  localparam logic [N-1:0] MSB_ONLY = {1'b1, {(N-1){1'b0}}};

  srm_sar_state_t state_r;
  logic [N-1:0] code_r;       // approximation register, drives the capacitor dac
  logic [N-1:0] mask_r;       // one-hot bit under test
  logic [7:0] acq_cnt_r;      // acquisition tick count
  logic [N-1:0] result_r;     // last complete result
  logic done_r;

  // decision of the bit under test and the trial code that follows it
  wire logic [N-1:0] decided = i_cmp ? code_r : (code_r & ~mask_r);
  wire logic [N-1:0] next_trial = decided | (mask_r >> 1);
  wire logic last_bit = mask_r[0];
  wire logic acq_end = (acq_cnt_r == 8'(ACQ - 1));

  // phase outputs decode the state; gap states keep phi1 and phi2 apart
  assign o_busy = (state_r != S_IDLE);
  assign o_acq = (state_r == S_ACQ);
  assign o_phi1 = (state_r == S_PHI1);
  assign o_phi2 = (state_r == S_PHI2);
  assign o_code = code_r;
  assign o_result = result_r;
  assign o_done = done_r;

  // sequencing: each trial phase lasts one tick, acquisition ACQ ticks; one trial per bit
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_r <= S_IDLE;
      code_r <= '0;
      mask_r <= '0;
      acq_cnt_r <= 8'h00;
      result_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      unique case (state_r)
        S_IDLE:
        begin
          if (i_start)
          begin
            state_r <= S_ACQ;
            acq_cnt_r <= 8'h00;
          end
        end
        S_ACQ:
        begin
          if (i_tick)
          begin
            if (acq_end)
              state_r <= S_ISO;
            else
              acq_cnt_r <= acq_cnt_r + 8'h01;
          end
        end
        S_ISO:
        begin
          if (i_tick)
          begin
            code_r <= MSB_ONLY;
            mask_r <= MSB_ONLY;
            state_r <= S_PHI1;
          end
        end
        S_PHI1:
          if (i_tick) state_r <= S_GAP1;
        S_GAP1:
          if (i_tick) state_r <= S_PHI2;
        S_PHI2:
          if (i_tick) state_r <= S_GAP2;
        S_GAP2:
        begin
          // comparator has had a full tick after phi2 to settle and sync
          if (i_tick)
          begin
            if (last_bit)
            begin
              code_r <= decided;
              result_r <= decided;
              done_r <= 1'b1;
              state_r <= S_IDLE;
            end
            else
            begin
              code_r <= next_trial;
              mask_r <= mask_r >> 1;
              state_r <= S_PHI1;
            end
          end
        end
      endcase
    end
  end
endmodule : srm_sar_engine

`default_nettype wire

// File: srm_remote_combine.sv
// weighted combination of the three delta-vbe conversions into a remote
// temperature code, saturated to a signed result.
// assumes the inputs are stable register contents; purely combinational.
`timescale 1ns/10ps
`default_nettype none

module srm_remote_combine
  import srm_pkg::*;
#(
  parameter int W1 = RCOMB_W1,
  parameter int W2 = RCOMB_W2,
  parameter int W3 = RCOMB_W3,
  parameter int SHIFT = RCOMB_SHIFT
)
(
  input wire logic [RES_BITS-1:0] i_d1,
  input wire logic [RES_BITS-1:0] i_d2,
  input wire logic [RES_BITS-1:0] i_d3,
  output logic [RES_BITS-1:0] o_temp
);
  localparam logic signed [23:0] SAT_HI = 24'sh0001ff;
  localparam logic signed [23:0] SAT_LO = -24'sh000200;

  // weights applied to unsigned codes; resistance terms cancel in the sum
  wire logic signed [23:0] sum = 24'(W1) * $signed({14'h0000, i_d1})
                               + 24'(W2) * $signed({14'h0000, i_d2})
                               + 24'(W3) * $signed({14'h0000, i_d3});
  wire logic signed [23:0] scaled = sum >>> SHIFT;

  // saturate rather than wrap so a faulty diode never reads as a sane value
  assign o_temp = (scaled > SAT_HI) ? SAT_HI[RES_BITS-1:0] :
                  (scaled < SAT_LO) ? SAT_LO[RES_BITS-1:0] :
                  scaled[RES_BITS-1:0];
endmodule : srm_remote_combine

`default_nettype wire

// File: srm_monitor.sv
// top of the round-robin monitor: two voltage sequencers, one temperature
// sequencer with chopped remote bias, three sar engines and the value registers.
// assumes comparator outputs arrive asynchronously from the analog front end,
// and that the serial host interface reads the value outputs directly.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - three converters, each fed by its own mux
// - each converter yields a ten-bit sar result
// - one approximation period per result bit
// - acquire onto array, isolate, then convert
// - non-overlapping phi1 grounds, phi2 applies trial
// - conversion starts with only msb set
// - keep tested bit when comparator high, else clear
// - hold decided bit, set next lower bit
// - each step result stored in approximation register
// - results presented for serial host reads
// - inputs one to eight cycle on low converter
// - inputs nine to sixteen cycle on high converter
// - local and remote temperature share third converter
// - result written to the channel just converted
// - remote bias steps base against three multiples
// - remote temperature from all three differences
// - temperature held until whole round completes
module srm_monitor
  import srm_pkg::*;
#(
  parameter int TICKS = TICK_DIV,
  parameter int SETTLE = SETTLE_TICKS
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_monitor_en,
  input wire logic i_cmp_low,
  input wire logic i_cmp_high,
  input wire logic i_cmp_temp,
  output logic [CH_W-1:0] o_sel_low,
  output logic [CH_W-1:0] o_sel_high,
  output logic o_temp_sel,
  output logic [1:0] o_bias_level,
  output logic o_acq_low,
  output logic o_phi1_low,
  output logic o_phi2_low,
  output logic [RES_BITS-1:0] o_code_low,
  output logic o_acq_high,
  output logic o_phi1_high,
  output logic o_phi2_high,
  output logic [RES_BITS-1:0] o_code_high,
  output logic o_acq_temp,
  output logic o_phi1_temp,
  output logic o_phi2_temp,
  output logic [RES_BITS-1:0] o_code_temp,
  output logic [NUM_VIN-1:0][RES_BITS-1:0] o_vin_value,
  output logic [NUM_VIN-1:0] o_vin_update,
  output logic [RES_BITS-1:0] o_local_temp,
  output logic [RES_BITS-1:0] o_remote_temp,
  output logic o_temp_update
);
  typedef enum logic [2:0] {
    TS_IDLE, TS_LOCAL_GO, TS_LOCAL_WAIT, TS_SETTLE, TS_REM_GO, TS_REM_WAIT, TS_PUBLISH
  } srm_temp_state_t;

  localparam logic [7:0] TICK_LAST = 8'(TICKS - 1);
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE - 1);
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(GROUP_CH - 1);

  // comparator synchronisers: s1 feeds only s2; s2/s3 agreement updates the level
  logic [NUM_CONV-1:0] cmp_s1_r;
  logic [NUM_CONV-1:0] cmp_s2_r;
  logic [NUM_CONV-1:0] cmp_s3_r;
  logic [NUM_CONV-1:0] cmp_f_r;   // filtered comparator level, index 0 low, 1 high, 2 temp

  logic [7:0] div_cnt_r;          // approximation tick divider
  logic tick_r;                   // one-cycle tick pulse

  // voltage groups
  logic [CH_W-1:0] ch_r [0:1];    // current channel of each group
  logic [1:0] v_start;
  logic [1:0] v_busy;
  logic [1:0] v_done;
  logic [1:0] v_acq, v_phi1, v_phi2; // engine phases toward the front end
  logic [RES_BITS-1:0] v_code [0:1]; // trial codes toward the capacitor dacs
  logic [RES_BITS-1:0] v_result [0:1];
  logic [RES_BITS-1:0] vin_val_r [0:NUM_VIN-1]; // value registers, inputs one to sixteen
  logic [NUM_VIN-1:0] vin_upd_r;

  // temperature side
  srm_temp_state_t ts_r;
  logic [1:0] step_r;             // bias multiple under measurement, 1..3
  logic [7:0] settle_cnt_r;
  logic chop_r;                   // alternates base and multiple each tick
  logic [RES_BITS-1:0] local_raw_r;
  logic [RES_BITS-1:0] rem_d_r [0:2];
  logic [RES_BITS-1:0] local_temp_r;
  logic [RES_BITS-1:0] remote_temp_r;
  logic temp_upd_r;
  logic t_busy;
  logic t_done;
  logic [RES_BITS-1:0] t_result;
  logic [RES_BITS-1:0] rem_comb;

  wire logic [NUM_CONV-1:0] cmp_diff = cmp_s2_r ^ cmp_s3_r;
  wire logic [NUM_CONV-1:0] cmp_f_nxt = (cmp_s2_r & ~cmp_diff) | (cmp_f_r & cmp_diff);
  wire logic t_start = (ts_r == TS_LOCAL_GO) || (ts_r == TS_REM_GO);
  wire logic remote_phase = (ts_r == TS_SETTLE) || (ts_r == TS_REM_GO) ||
                            (ts_r == TS_REM_WAIT);

  // synchronise the three asynchronous comparator outputs
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cmp_s1_r <= 3'h0;
      cmp_s2_r <= 3'h0;
      cmp_s3_r <= 3'h0;
      cmp_f_r <= 3'h0;
    end
    else
    begin
      cmp_s1_r <= {i_cmp_temp, i_cmp_high, i_cmp_low};
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      cmp_f_r <= cmp_f_nxt;
    end
  end

  // tick divider shared by all three engines
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      div_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_cnt_r == TICK_LAST);
      div_cnt_r <= (div_cnt_r == TICK_LAST) ? 8'h00 : div_cnt_r + 8'h01;
    end
  end

  // two voltage converters, each with its own round-robin channel counter
  for (genvar g = 0; g < 2; g++)
  begin : g_volt
    // never start in the done cycle, so the mux moves before the next acquisition
    assign v_start[g] = i_monitor_en & ~v_busy[g] & ~v_done[g];

    srm_sar_engine #(.N(RES_BITS), .ACQ(ACQ_TICKS)) u_conv (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_tick(tick_r),
      .i_start(v_start[g]),
      .i_cmp(cmp_f_r[g]),
      .o_busy(v_busy[g]),
      .o_acq(v_acq[g]),
      .o_phi1(v_phi1[g]),
      .o_phi2(v_phi2[g]),
      .o_code(v_code[g]),
      .o_result(v_result[g]),
      .o_done(v_done[g])
    );

    // advance after each completed conversion, wrapping to the first input
    always_ff @(posedge i_clk)
    begin
      if (i_sys_rst)
        ch_r[g] <= '0;
      else if (v_done[g])
        ch_r[g] <= (ch_r[g] == CH_LAST) ? '0 : ch_r[g] + CH_W'(1);
    end
  end

  // engine phase outputs reach the front end through the ports
  assign o_acq_low = v_acq[0];
  assign o_phi1_low = v_phi1[0];
  assign o_phi2_low = v_phi2[0];
  assign o_code_low = v_code[0];
  assign o_acq_high = v_acq[1];
  assign o_phi1_high = v_phi1[1];
  assign o_phi2_high = v_phi2[1];
  assign o_code_high = v_code[1];
  assign o_sel_low = ch_r[0];
  assign o_sel_high = ch_r[1];

  // voltage value registers: low group fills 0..7, high group 8..15
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < NUM_VIN; i++)
        vin_val_r[i] <= '0;
      vin_upd_r <= '0;
    end
    else
    begin
      vin_upd_r <= '0;
      for (int g = 0; g < 2; g++)
      begin
        if (v_done[g])
        begin
          vin_val_r[{g[0], ch_r[g]}] <= v_result[g];
          vin_upd_r[{g[0], ch_r[g]}] <= 1'b1;
        end
      end
    end
  end

  for (genvar i = 0; i < NUM_VIN; i++)
  begin : g_vout
    assign o_vin_value[i] = vin_val_r[i];
  end
  assign o_vin_update = vin_upd_r;

  // third converter, shared by local and remote temperature
  srm_sar_engine #(.N(RES_BITS), .ACQ(ACQ_TICKS)) u_conv_temp (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick_r),
    .i_start(t_start),
    .i_cmp(cmp_f_r[2]),
    .o_busy(t_busy),
    .o_acq(o_acq_temp),
    .o_phi1(o_phi1_temp),
    .o_phi2(o_phi2_temp),
    .o_code(o_code_temp),
    .o_result(t_result),
    .o_done(t_done)
  );

  srm_remote_combine u_combine (
    .i_d1(rem_d_r[0]),
    .i_d2(rem_d_r[1]),
    .i_d3(rem_d_r[2]),
    .o_temp(rem_comb)
  );

  // bias chops between base and the current multiple while measuring remote
  assign o_temp_sel = remote_phase ? TEMP_SEL_REMOTE : TEMP_SEL_LOCAL;
  assign o_bias_level = (remote_phase && chop_r) ? step_r : BIAS_BASE;

  // temperature round: local, then three remote differences, then publish
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ts_r <= TS_IDLE;
      step_r <= BIAS_N1;
      settle_cnt_r <= 8'h00;
      chop_r <= 1'b0;
      local_raw_r <= '0;
      for (int k = 0; k < 3; k++)
        rem_d_r[k] <= '0;
    end
    else
    begin
      if (tick_r)
        chop_r <= remote_phase ? ~chop_r : 1'b0;
      unique case (ts_r)
        TS_IDLE:
          if (i_monitor_en && !t_busy) ts_r <= TS_LOCAL_GO;
        TS_LOCAL_GO:
          ts_r <= TS_LOCAL_WAIT;
        TS_LOCAL_WAIT:
        begin
          if (t_done)
          begin
            local_raw_r <= t_result;
            step_r <= BIAS_N1;
            settle_cnt_r <= 8'h00;
            ts_r <= TS_SETTLE;
          end
        end
        TS_SETTLE:
        begin
          // the chopped difference needs time through the filter before sampling
          if (tick_r)
          begin
            if (settle_cnt_r == SETTLE_LAST)
              ts_r <= TS_REM_GO;
            else
              settle_cnt_r <= settle_cnt_r + 8'h01;
          end
        end
        TS_REM_GO:
          ts_r <= TS_REM_WAIT;
        TS_REM_WAIT:
        begin
          if (t_done)
          begin
            rem_d_r[step_r - 2'h1] <= t_result;
            settle_cnt_r <= 8'h00;
            if (step_r == BIAS_N3)
              ts_r <= TS_PUBLISH;
            else
            begin
              step_r <= step_r + 2'h1;
              ts_r <= TS_SETTLE;
            end
          end
        end
        TS_PUBLISH:
          ts_r <= TS_IDLE;
      endcase
    end
  end

  // temperature values change only once a whole round has finished
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      local_temp_r <= '0;
      remote_temp_r <= '0;
      temp_upd_r <= 1'b0;
    end
    else
    begin
      temp_upd_r <= (ts_r == TS_PUBLISH);
      if (ts_r == TS_PUBLISH)
      begin
        local_temp_r <= local_raw_r;
        remote_temp_r <= rem_comb;
      end
    end
  end

  assign o_local_temp = local_temp_r;
  assign o_remote_temp = remote_temp_r;
  assign o_temp_update = temp_upd_r;
endmodule : srm_monitor

`default_nettype wire

// File: srm_monitor_asserts.sv
// checker for the monitor top: phase, sequencing and value-register relations.
// assumes it is bound to srm_monitor and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module srm_monitor_asserts
  import srm_pkg::*;
#(
  parameter int TICKS = TICK_DIV,
  parameter int SETTLE = SETTLE_TICKS
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [CH_W-1:0] o_sel_low,
  input wire logic [CH_W-1:0] o_sel_high,
  input wire logic o_temp_sel,
  input wire logic [1:0] o_bias_level,
  input wire logic o_acq_low,
  input wire logic o_phi1_low,
  input wire logic o_phi2_low,
  input wire logic o_phi1_high,
  input wire logic o_phi2_high,
  input wire logic [RES_BITS-1:0] o_code_low,
  input wire logic o_acq_temp,
  input wire logic o_phi1_temp,
  input wire logic o_phi2_temp,
  input wire logic [NUM_VIN-1:0][RES_BITS-1:0] o_vin_value,
  input wire logic [NUM_VIN-1:0] o_vin_update,
  input wire logic [RES_BITS-1:0] o_local_temp,
  input wire logic [RES_BITS-1:0] o_remote_temp,
  input wire logic o_temp_update
);
  localparam int MSB_HI = 3 * TICKS; // first trial lands before the second one
  localparam int SPAN_LO = 40 * TICKS; // isolation plus ten trials, less jitter
  localparam int SPAN_HI = 42 * TICKS + 4; // tick phase may add almost a tick
  logic phi_d_r; // phi1 one cycle back, for edge counting
  logic [15:0] span_r; // clocks since the low array was isolated
  logic [3:0] trials_r; // phi1 pulses in the running low conversion

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // counters restart while the array samples, so each conversion is measured alone
  always_ff @(posedge i_clk)
  begin
    phi_d_r <= o_phi1_low;
    span_r <= (i_sys_rst || o_acq_low) ? 16'h0 : span_r + 16'h1;
    if (i_sys_rst || o_acq_low)
      trials_r <= 4'h0;
    else if (o_phi1_low && !phi_d_r)
      trials_r <= trials_r + 4'h1;
  end

  a_phase_overlap: assert property (!(o_phi1_low && o_phi2_low)
    && !(o_phi1_high && o_phi2_high) && !(o_phi1_temp && o_phi2_temp))
    else $error("phase clocks overlap");
  a_acq_isolated: assert property (!(o_acq_low && (o_phi1_low || o_phi2_low))
    && !(o_acq_temp && (o_phi1_temp || o_phi2_temp)))
    else $error("trial phase during acquisition");
  a_msb_first: assert property ($fell(o_acq_low) |->
    ##[1:MSB_HI] (o_phi1_low && o_code_low == 10'h200))
    else $error("first trial code is not msb only");
  a_trial_steady: assert property (o_phi2_low |-> $stable(o_code_low))
    else $error("trial code moved during phi2");
  a_ten_trials: assert property (|o_vin_update[7:0] |-> trials_r == 4'ha)
    else $error("result written after wrong trial count");
  a_conv_span: assert property (|o_vin_update[7:0] |->
    span_r >= SPAN_LO && span_r <= SPAN_HI)
    else $error("conversion length off");
  a_sel_wrap_low: assert property ($changed(o_sel_low) |->
    o_sel_low == $past(o_sel_low) + 3'h1
    && ((o_vin_update | $past(o_vin_update)) & 16'h00ff) != 16'h0)
    else $error("low select skipped or moved early");
  a_sel_wrap_high: assert property ($changed(o_sel_high) |->
    o_sel_high == $past(o_sel_high) + 3'h1
    && ((o_vin_update | $past(o_vin_update)) & 16'hff00) != 16'h0)
    else $error("high select skipped or moved early");
  a_update_pulse: assert property ((o_vin_update & $past(o_vin_update)) == 16'h0
    && $countones(o_vin_update[7:0]) <= 1 && $countones(o_vin_update[15:8]) <= 1)
    else $error("update pulse too long or not single");
  a_temp_hold: assert property (($changed(o_local_temp) || $changed(o_remote_temp))
    |-> ##[0:1] o_temp_update)
    else $error("temperature moved without publish");
  a_bias_local: assert property (!o_temp_sel |-> o_bias_level == BIAS_BASE)
    else $error("bias stepped while local selected");
  for (genvar k = 0; k < NUM_VIN; k++)
  begin : g_val
    a_value_write: assert property ($changed(o_vin_value[k]) |-> ##[0:1] o_vin_update[k])
      else $error("value changed without its update");
  end
endmodule : srm_monitor_asserts

bind srm_monitor srm_monitor_asserts #(.TICKS(TICKS), .SETTLE(SETTLE)) srm_monitor_asserts_i (
  .i_clk, .i_sys_rst, .o_sel_low, .o_sel_high, .o_temp_sel, .o_bias_level, .o_acq_low,
  .o_phi1_low, .o_phi2_low, .o_code_low, .o_acq_temp, .o_phi1_temp, .o_phi2_temp,
  .o_phi1_high, .o_phi2_high,
  .o_vin_value, .o_vin_update, .o_local_temp, .o_remote_temp, .o_temp_update);

`default_nettype wire

// File: srm_afe_model.sv
// behavioural analog front end: input muxes, sampling arrays and comparators.
// assumes the monitor's selects, acquisition levels and trial codes at its ports.
`timescale 1ns/10ps
`default_nettype none

module srm_afe_model
  import srm_pkg::*;
(
  input wire logic i_clk,
  input wire logic [NUM_VIN-1:0][RES_BITS-1:0] i_vin_level,
  input wire logic [RES_BITS-1:0] i_local_level,
  input wire logic [2:0][RES_BITS-1:0] i_delta_level,
  input wire logic [CH_W-1:0] i_sel_low,
  input wire logic [CH_W-1:0] i_sel_high,
  input wire logic i_temp_sel,
  input wire logic [1:0] i_bias_level,
  input wire logic i_acq_low,
  input wire logic i_acq_high,
  input wire logic i_acq_temp,
  input wire logic [RES_BITS-1:0] i_code_low,
  input wire logic [RES_BITS-1:0] i_code_high,
  input wire logic [RES_BITS-1:0] i_code_temp,
  output logic o_cmp_low,
  output logic o_cmp_high,
  output logic o_cmp_temp
);
  logic [RES_BITS-1:0] held_low_r = 10'h0; // charge kept on the low array
  logic [RES_BITS-1:0] held_high_r = 10'h0; // charge kept on the high array
  logic [RES_BITS-1:0] held_temp_r = 10'h0; // charge kept on the temperature array
  logic [1:0] step_r = 2'h0; // remote difference now being acquired

  // arrays track the input only while sampling; the remote step follows the bias
  // level, so a wrong bias sequence shows up as a wrong remote value
  always @(negedge i_clk)
  begin
    if (i_acq_low)
      held_low_r <= i_vin_level[{1'b0, i_sel_low}];
    if (i_acq_high)
      held_high_r <= i_vin_level[{1'b1, i_sel_high}];
    if (!i_temp_sel)
      step_r <= 2'h0;
    else if (i_bias_level != BIAS_BASE)
      step_r <= i_bias_level - 2'h1;
    if (i_acq_temp)
      held_temp_r <= i_temp_sel ? i_delta_level[step_r] : i_local_level;
    // high means held input at or above the trial, so the search ends on the level
    o_cmp_low <= held_low_r >= i_code_low;
    o_cmp_high <= held_high_r >= i_code_high;
    o_cmp_temp <= held_temp_r >= i_code_temp;
  end
endmodule : srm_afe_model

`default_nettype wire

// File: srm_monitor_tb_top.sv
// self-checking bench: round robins, result values, temperature rounds, idle.
// assumes srm_monitor, srm_afe_model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module srm_monitor_tb_top
  import srm_pkg::*;
();
  localparam int TK = 4; // short tick keeps the run brief
  localparam int ST = 2; // short bias settling
  logic clk;
  logic sys_rst = 1'b1;
  logic monitor_en = 1'b0;
  logic cmp_low, cmp_high, cmp_temp;
  logic [CH_W-1:0] sel_low, sel_high;
  logic temp_sel, acq_low, acq_high, acq_temp;
  logic [1:0] bias_level;
  logic [RES_BITS-1:0] code_low, code_high, code_temp, local_temp, remote_temp;
  logic [NUM_VIN-1:0][RES_BITS-1:0] vin_value;
  logic [NUM_VIN-1:0] vin_update;
  logic temp_update;
  // levels cover both ends, midscale and alternating bits
  logic [NUM_VIN-1:0][RES_BITS-1:0] vin_level = {10'h201, 10'h002, 10'h355, 10'h0aa,
    10'h30f, 10'h0f0, 10'h300, 10'h100, 10'h3fe, 10'h001, 10'h2aa, 10'h155,
    10'h1ff, 10'h200, 10'h3ff, 10'h000};
  logic [RES_BITS-1:0] local_level = 10'h0;
  logic [2:0][RES_BITS-1:0] delta_level = '0;
  int err_total = 0;
  int cmp_count = 0;

  srm_monitor #(.TICKS(TK), .SETTLE(ST)) srm_monitor_i (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_monitor_en(monitor_en), .i_cmp_low(cmp_low),
    .i_cmp_high(cmp_high), .i_cmp_temp(cmp_temp), .o_sel_low(sel_low), .o_sel_high(sel_high),
    .o_temp_sel(temp_sel), .o_bias_level(bias_level), .o_acq_low(acq_low), .o_phi1_low(),
    .o_phi2_low(), .o_code_low(code_low), .o_acq_high(acq_high), .o_phi1_high(),
    .o_phi2_high(), .o_code_high(code_high), .o_acq_temp(acq_temp), .o_phi1_temp(),
    .o_phi2_temp(), .o_code_temp(code_temp), .o_vin_value(vin_value),
    .o_vin_update(vin_update), .o_local_temp(local_temp), .o_remote_temp(remote_temp),
    .o_temp_update(temp_update));

  srm_afe_model srm_afe_model_i (
    .i_clk(clk), .i_vin_level(vin_level), .i_local_level(local_level),
    .i_delta_level(delta_level), .i_sel_low(sel_low), .i_sel_high(sel_high),
    .i_temp_sel(temp_sel), .i_acq_low(acq_low), .i_acq_high(acq_high), .i_acq_temp(acq_temp),
    .i_bias_level(bias_level),
    .i_code_low(code_low), .i_code_high(code_high), .i_code_temp(code_temp),
    .o_cmp_low(cmp_low), .o_cmp_high(cmp_high), .o_cmp_temp(cmp_temp));

  // free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [RES_BITS-1:0] exp,
    input logic [RES_BITS-1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic timeout();
    err_total++;
    $display("mismatch wait expected event seen none");
    end_sim();
  endtask : timeout

  // twelve cycles of reset, then low select, value one and remote temp must read zero
  task automatic t_reset();
    sys_rst = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    chk("low select", 10'h0, {7'h0, sel_low});
    chk("value one", 10'h0, vin_value[0]);
    chk("remote temp", 10'h0, remote_temp);
  endtask : t_reset

  // both groups run past their wrap; order and each written value are judged
  task automatic t_voltage();
    int nxt[2];
    int seen;
    nxt = '{0, 8};
    seen = 0;
    for (int c = 0; c < 8000 && seen < 18; c++)
    begin
      @(negedge clk);
      for (int i = 0; i < NUM_VIN; i++)
        if (vin_update[i] === 1'b1)
        begin
          chk("channel", 10'(nxt[i / 8]), 10'(i));
          chk("value", vin_level[i], vin_value[i]);
          nxt[i / 8] = (i % 8 == 7) ? i - 7 : i + 1;
          seen++;
        end
    end
    if (seen < 18)
      timeout();
  endtask : t_voltage

  // two publishes: the first may mix old levels, the second must show the new ones
  task automatic t_temp(input logic [RES_BITS-1:0] loc, input logic [RES_BITS-1:0] d1,
    input logic [RES_BITS-1:0] d2, input logic [RES_BITS-1:0] d3,
    input logic [RES_BITS-1:0] exp_rem);
    int c;
    int moved;
    logic [RES_BITS-1:0] held;
    moved = 0;
    local_level = loc;
    delta_level = {d3, d2, d1};
    for (int r = 0; r < 2; r++)
    begin
      held = local_temp;
      c = 0;
      @(negedge clk);
      while (temp_update !== 1'b1 && c < 4000)
      begin
        if (local_temp !== held)
          moved++;
        @(negedge clk);
        c++;
      end
      if (c >= 4000)
        timeout();
    end
    chk("early temp change", 10'h0, 10'(moved));
    chk("local temp", loc, local_temp);
    chk("remote temp", exp_rem, remote_temp);
  endtask : t_temp

  // no new work while disabled, and the low round robin resumes once enabled again
  task automatic t_enable_off();
    int n;
    int c;
    n = 0;
    monitor_en = 1'b0;
    repeat (2000) @(negedge clk);
    for (int k = 0; k < 2000; k++)
    begin
      @(negedge clk);
      if (vin_update !== 16'h0 || temp_update !== 1'b0)
        n++;
    end
    chk("updates while idle", 10'h0, 10'(n));
    monitor_en = 1'b1;
    c = 0;
    while (vin_update[7:0] === 8'h0 && c < 1000)
    begin
      @(negedge clk);
      c++;
    end
    if (c >= 1000)
      timeout();
  endtask : t_enable_off

  // main sequence, all stimulus applied on falling edges
  initial
  begin
    t_reset();
    monitor_en = 1'b1;
    t_voltage();
    t_temp(10'h1a5, 10'h040, 10'h030, 10'h020, 10'h050);
    t_temp(10'h3ff, 10'h1ff, 10'h000, 10'h1ff, 10'h1ff);
    t_temp(10'h000, 10'h000, 10'h1ff, 10'h000, 10'h200);
    t_enable_off();
    t_reset();
    end_sim();
  end
endmodule : srm_monitor_tb_top

`default_nettype wire
